// ===== core/vccr_defs.svh
`ifndef VCCR_DEFS_SVH
`define VCCR_DEFS_SVH
// What this block does
// RQ1 - Receive gain upper nibble: earpiece attenuation 0 to -15 dB, 1 dB steps, 0 default.
// RQ2 - Receive gain lower nibble: loudspeaker attenuation 0 to -30 dB in 2 dB steps.
// RQ3 - Tone control upper nibble: tone level 0 to -27 dB, 3 dB steps; higher reserved.
// RQ4 - Tone control bits 3:2 select sources: mute, second, first, both summed.
// RQ5 - Tone control bit 0 routes tone generator to transmit data path; clear is normal.
// RQ6 - Each frequency register holds an 8-bit unsigned number, msb at bit 7.
// RQ7 - Standard range: tone frequency equals register value over 0.128 Hz, about 7.8 Hz step.
// RQ8 - Anticlipping bit 7 selects speaker maximum gain +27 dB or +9 dB; 0 default.
// RQ9 - Anticlipping bit 6 enables automatic anticlipping; cleared at power-on.
// RQ10 - Anticlipping bits 5:4 select threshold -15, -13, -9 or -7 dBm0.
// RQ11 - Anticlipping bits 3:2 select recovery 256, 128, 32 or 16 ms.
// RQ12 - Anticlipping bits 1:0 select tone range standard, halved, doubled; 11 never written.
// RQ13 - Every anticlipping field takes its default at power-on.
// RQ14 - Separate control mode: host supplies 512 kHz, 1.536, 2.048 or 2.56 MHz clock.
// RQ15 - Host programs configuration bits 7:6 at start to match the supplied clock.
// RQ16 - GCI mode: master clock 1.536 or 2.048 MHz only.
// RQ17 - Clock selection defaults to 1.536 MHz; other choices written before power-up.
// RQ18 - Configuration bits 5:4 select companding law; mu-law after power-on.
// RQ19 - Law codes: mu D3/D4, mu bare, A-law even-bit inversion, A-law bare.
// RQ20 - PCM bytes shift in and out most significant bit first.
// RQ21 - Configuration bit 3: delayed timing at 0, non-delayed at 1; ignored in GCI.
// RQ22 - Configuration bit 2: B channels consecutive at 0, two bits apart at 1; ignored in GCI.
// RQ23 - Configuration bit 1: ignore received lsb, transmit lsb slot high impedance.
// RQ24 - Configuration bit 0: loopback retransmits received byte unchanged in transmit slot.
// RQ25 - During loopback no encode or decode, transmit and receive amplifiers muted.
// RQ26 - Tone control bit 1 selects sinewave or squarewave; squarewave at power-on.
// RQ27 - Host writes zero to reserved codes; writes take effect after both bytes.
// RQ28 - Reads return last written value or the power-on default.

// Register numbers carried in the address byte
`define VCCR_ADDR_GENCFG     4'h0
`define VCCR_ADDR_RXGAIN     4'h6
`define VCCR_ADDR_TONECTL    4'h7
`define VCCR_ADDR_FREQ1      4'h8
`define VCCR_ADDR_FREQ2      4'h9
`define VCCR_ADDR_ANTICLIP   4'ha
// Address byte layout
`define VCCR_CMD_READ_BIT    7
`define VCCR_CMD_ADDR_LSB    0
// Reset values
`define VCCR_RST_GENCFG      8'h40
`define VCCR_RST_RXGAIN      8'h00
`define VCCR_RST_TONECTL     8'h00
`define VCCR_RST_FREQ        8'h00
`define VCCR_RST_ANTICLIP    8'h00
// Field positions
`define VCCR_CLKSEL_LSB      6
`define VCCR_LAW_BIT         5
`define VCCR_INV_BIT         4
`define VCCR_TIMING_BIT      3
`define VCCR_FORMAT_BIT      2
`define VCCR_SEVEN_BIT       1
`define VCCR_LOOP_BIT        0
`define VCCR_EAR_LSB         4
`define VCCR_SPK_LSB         0
`define VCCR_TLEVEL_LSB      4
`define VCCR_TONE1_BIT       3
`define VCCR_TONE2_BIT       2
`define VCCR_WAVE_BIT        1
`define VCCR_TONE_TX_BIT     0
`define VCCR_BOOST_BIT       7
`define VCCR_ACE_BIT         6
`define VCCR_THR_LSB         4
`define VCCR_REC_LSB         2
`define VCCR_DOUBLE_BIT      1
`define VCCR_HALF_BIT        0
// Highest legal tone level code
`define VCCR_TLEVEL_MAX      4'h9
`endif

// ===== core/vccr_pkg.sv
package vccr_pkg;
    typedef enum logic [2:0] {
        VCCR_SP_IDLE = 3'b001,
        VCCR_SP_ADDR = 3'b010,
        VCCR_SP_DATA = 3'b100
    } vccr_sp_state_e;
    typedef logic [7:0] vccr_byte_t;
    typedef logic [2:0] vccr_slot_t;
endpackage

// ===== core/vccr_regs.sv
`timescale 1ns/10ps
`include "vccr_defs.svh"
module vccr_regs (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Serial control channel
    input  wire logic             i_cs_b,
    input  wire logic             i_sclk,
    input  wire logic             i_sdi,
    output logic                  o_sdo,
    output logic                  o_sdo_oe,
    // Mode strap
    input  wire logic             i_gci_mode,
    // PCM receive side
    input  wire logic             i_dr,
    input  wire logic             i_rx_bit_en,
    input  wire logic             i_rx_slot_start,
    // PCM transmit side and decoded receive byte
    input  wire vccr_pkg::vccr_byte_t i_enc_byte,
    input  wire logic             i_tx_bit_en,
    input  wire logic             i_tx_slot_start,
    output logic                  o_dx,
    output logic                  o_dx_oe,
    output vccr_pkg::vccr_byte_t  o_dec_byte,
    output logic                  o_dec_valid,
    // Receive amplifier controls
    output logic [3:0]            o_ear_atten,
    output logic [3:0]            o_spk_atten,
    // Tone generator controls
    output logic [3:0]            o_tone_level,
    output logic                  o_first_tone_enable,
    output logic                  o_second_tone_enable,
    output logic                  o_waveform_select,
    output logic                  o_tone_to_transmit,
    output logic [10:0]           o_first_tone_step,
    output logic [10:0]           o_second_tone_step,
    // Loudspeaker and anticlipping
    output logic                  o_speaker_boost,
    output logic                  o_anticlip_enable,
    output logic [1:0]            o_threshold_sel,
    output logic [1:0]            o_recovery_sel,
    // General configuration
    output logic [1:0]            o_clock_divider_sel,
    output logic                  o_alaw,
    output logic                  o_mu_d3d4,
    output logic                  o_even_bit_invert,
    output logic                  o_non_delayed,
    output logic                  o_format_separated,
    output logic                  o_seven_bit_mode,
    output logic                  o_codec_bypass,
    output logic                  o_amp_mute
);
    import vccr_pkg::*;

    localparam vccr_slot_t SLOT_NONE = 3'h7;

    function automatic vccr_slot_t reg_slot(input logic [3:0] addr);
        unique case (addr)
            `VCCR_ADDR_GENCFG:   reg_slot = 3'h0;
            `VCCR_ADDR_RXGAIN:   reg_slot = 3'h1;
            `VCCR_ADDR_TONECTL:  reg_slot = 3'h2;
            `VCCR_ADDR_FREQ1:    reg_slot = 3'h3;
            `VCCR_ADDR_FREQ2:    reg_slot = 3'h4;
            `VCCR_ADDR_ANTICLIP: reg_slot = 3'h5;
            default:             reg_slot = SLOT_NONE;
        endcase
    endfunction

    // Tone step in 1/0.512 Hz units: standard x4, halved x2, doubled x8
    function automatic logic [10:0] tone_step(input vccr_byte_t f, input logic dbl,
                                              input logic half);
        if (dbl) begin
            tone_step = {f, 3'h0};
        end else if (half) begin
            tone_step = {1'h0, f, 2'h0} >> 1;
        end else begin
            tone_step = {1'h0, f, 2'h0};
        end
    endfunction

    localparam vccr_byte_t RST_VAL [0:5] = '{`VCCR_RST_GENCFG, `VCCR_RST_RXGAIN,
        `VCCR_RST_TONECTL, `VCCR_RST_FREQ, `VCCR_RST_FREQ, `VCCR_RST_ANTICLIP};

    vccr_sp_state_e sp_state_q;
    logic           sclk_q;
    logic [2:0]     bit_cnt_q;
    vccr_byte_t     sp_shift_q;
    vccr_byte_t     sdo_shift_q;
    logic           rd_q;
    vccr_slot_t     slot_q;
    vccr_byte_t     regs_q [0:5];
    logic           sclk_rise;
    logic           sclk_fall;
    vccr_byte_t     rx_byte_d;
    vccr_byte_t     rd_val;
    vccr_slot_t     cmd_slot;

    assign sclk_rise = i_sclk & ~sclk_q;
    assign sclk_fall = ~i_sclk & sclk_q;
    assign rx_byte_d = {sp_shift_q[6:0], i_sdi};
    assign cmd_slot  = reg_slot(rx_byte_d[`VCCR_CMD_ADDR_LSB +: 4]);
    assign rd_val    = (cmd_slot == SLOT_NONE) ? 8'h00 : regs_q[cmd_slot];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= i_sclk;
        end
    end

    // Control instruction: address byte then data byte, msb first
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sp_state_q  <= VCCR_SP_IDLE;
            bit_cnt_q   <= 3'h0;
            sp_shift_q  <= 8'h00;
            rd_q        <= 1'b0;
            slot_q      <= SLOT_NONE;
        end else if (i_cs_b) begin
            sp_state_q <= VCCR_SP_IDLE;
            bit_cnt_q  <= 3'h0;
        end else begin
            unique case (sp_state_q)
                VCCR_SP_IDLE: begin
                    sp_state_q <= VCCR_SP_ADDR;
                    bit_cnt_q  <= 3'h0;
                end
                VCCR_SP_ADDR: begin
                    if (sclk_rise) begin
                        sp_shift_q <= rx_byte_d;
                        bit_cnt_q  <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            sp_state_q <= VCCR_SP_DATA;
                            rd_q       <= rx_byte_d[`VCCR_CMD_READ_BIT];
                            slot_q     <= cmd_slot;
                        end
                    end
                end
                VCCR_SP_DATA: begin
                    if (sclk_rise) begin
                        sp_shift_q <= rx_byte_d;
                        bit_cnt_q  <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            sp_state_q <= VCCR_SP_ADDR;
                        end
                    end
                end
            endcase
        end
    end

    // Register bank, committed only once the second byte is complete
    generate
        for (genvar g = 0; g < 6; g++) begin : g_reg
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    regs_q[g] <= RST_VAL[g]; // RQ1 RQ13 RQ17 RQ18
                end else if (!i_cs_b && sp_state_q == VCCR_SP_DATA && sclk_rise
                             && bit_cnt_q == 3'h7 && !rd_q
                             && slot_q == vccr_slot_t'(g)) begin
                    regs_q[g] <= rx_byte_d; // RQ27
                end
            end
        end
    endgenerate

    // Read data leaves msb first: msb on the last address rise, later bits changing on each falling clock edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sdo_shift_q <= 8'h00;
            o_sdo       <= 1'b0;
            o_sdo_oe    <= 1'b0;
        end else if (i_cs_b) begin
            o_sdo_oe <= 1'b0;
        end else if (sp_state_q == VCCR_SP_ADDR && sclk_rise && bit_cnt_q == 3'h7) begin
            sdo_shift_q <= {rd_val[6:0], 1'b0}; // RQ28
            o_sdo       <= rd_val[7];
            o_sdo_oe    <= rx_byte_d[`VCCR_CMD_READ_BIT];
        end else if (sp_state_q == VCCR_SP_DATA && sclk_fall) begin
            o_sdo       <= sdo_shift_q[7];
            sdo_shift_q <= {sdo_shift_q[6:0], 1'b0};
        end else if (sp_state_q == VCCR_SP_ADDR && sclk_fall) begin
            // Fall after the last data bit ends the read byte
            o_sdo_oe <= 1'b0; // RQ28
        end
    end

    // Decoded controls
    vccr_byte_t cfg;
    vccr_byte_t rxg;
    vccr_byte_t tct;
    vccr_byte_t acl;
    assign cfg = regs_q[0];
    assign rxg = regs_q[1];
    assign tct = regs_q[2];
    assign acl = regs_q[5];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ear_atten          <= 4'h0;
            o_spk_atten          <= 4'h0;
            o_tone_level         <= 4'h0;
            o_first_tone_enable  <= 1'b0;
            o_second_tone_enable <= 1'b0;
            o_waveform_select    <= 1'b0;
            o_tone_to_transmit   <= 1'b0;
            o_first_tone_step    <= 11'h000;
            o_second_tone_step   <= 11'h000;
        end else begin
            o_ear_atten          <= rxg[`VCCR_EAR_LSB +: 4]; // RQ1
            o_spk_atten          <= rxg[`VCCR_SPK_LSB +: 4]; // RQ2
            // Reserved level codes hold at the deepest legal attenuation
            o_tone_level         <= (tct[`VCCR_TLEVEL_LSB +: 4] > `VCCR_TLEVEL_MAX) ?
                                    `VCCR_TLEVEL_MAX : tct[`VCCR_TLEVEL_LSB +: 4]; // RQ3
            o_first_tone_enable  <= tct[`VCCR_TONE1_BIT]; // RQ4
            o_second_tone_enable <= tct[`VCCR_TONE2_BIT]; // RQ4
            o_waveform_select    <= tct[`VCCR_WAVE_BIT]; // RQ26
            o_tone_to_transmit   <= tct[`VCCR_TONE_TX_BIT]; // RQ5
            o_first_tone_step    <= tone_step(regs_q[3], acl[`VCCR_DOUBLE_BIT],
                                              acl[`VCCR_HALF_BIT]); // RQ6 RQ7 RQ12
            o_second_tone_step   <= tone_step(regs_q[4], acl[`VCCR_DOUBLE_BIT],
                                              acl[`VCCR_HALF_BIT]); // RQ6 RQ7 RQ12
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_speaker_boost     <= 1'b0;
            o_anticlip_enable   <= 1'b0;
            o_threshold_sel     <= 2'h0;
            o_recovery_sel      <= 2'h0;
            o_clock_divider_sel <= 2'h1;
            o_alaw              <= 1'b0;
            o_mu_d3d4           <= 1'b1;
            o_even_bit_invert   <= 1'b0;
            o_non_delayed       <= 1'b0;
            o_format_separated  <= 1'b0;
            o_seven_bit_mode    <= 1'b0;
            o_codec_bypass      <= 1'b0;
            o_amp_mute          <= 1'b0;
        end else begin
            o_speaker_boost     <= acl[`VCCR_BOOST_BIT]; // RQ8
            o_anticlip_enable   <= acl[`VCCR_ACE_BIT]; // RQ9
            o_threshold_sel     <= acl[`VCCR_THR_LSB +: 2]; // RQ10
            o_recovery_sel      <= acl[`VCCR_REC_LSB +: 2]; // RQ11
            o_clock_divider_sel <= cfg[`VCCR_CLKSEL_LSB +: 2]; // RQ15
            o_alaw              <= cfg[`VCCR_LAW_BIT]; // RQ18
            o_mu_d3d4           <= !cfg[`VCCR_LAW_BIT] && !cfg[`VCCR_INV_BIT]; // RQ19
            o_even_bit_invert   <= cfg[`VCCR_LAW_BIT] && !cfg[`VCCR_INV_BIT]; // RQ19
            o_non_delayed       <= cfg[`VCCR_TIMING_BIT] && !i_gci_mode; // RQ21
            o_format_separated  <= cfg[`VCCR_FORMAT_BIT] && !i_gci_mode; // RQ22
            o_seven_bit_mode    <= cfg[`VCCR_SEVEN_BIT]; // RQ23
            o_codec_bypass      <= cfg[`VCCR_LOOP_BIT]; // RQ25
            o_amp_mute          <= cfg[`VCCR_LOOP_BIT]; // RQ25
        end
    end

    // PCM receive slot, msb first
    vccr_byte_t rx_sh_q;
    vccr_byte_t loop_byte_q;
    logic [3:0] rx_cnt_q;
    vccr_byte_t rx_full;
    assign rx_full = {rx_sh_q[6:0], i_dr};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_sh_q     <= 8'h00;
            rx_cnt_q    <= 4'h8;
            loop_byte_q <= 8'h00;
            o_dec_byte  <= 8'h00;
            o_dec_valid <= 1'b0;
        end else begin
            o_dec_valid <= 1'b0;
            if (i_rx_slot_start) begin
                rx_cnt_q <= 4'h0;
            end else if (i_rx_bit_en && rx_cnt_q != 4'h8) begin
                rx_sh_q  <= rx_full; // RQ20
                rx_cnt_q <= rx_cnt_q + 4'h1;
                if (rx_cnt_q == 4'h7) begin
                    if (cfg[`VCCR_LOOP_BIT]) begin
                        loop_byte_q <= rx_full; // RQ24
                    end else begin
                        o_dec_byte  <= {rx_full[7:1],
                                        rx_full[0] & ~cfg[`VCCR_SEVEN_BIT]}; // RQ23
                        o_dec_valid <= 1'b1; // RQ25
                    end
                end
            end
        end
    end

    // PCM transmit slot, msb first
    vccr_byte_t tx_sh_q;
    logic [3:0] tx_left_q;
    vccr_byte_t tx_src;
    assign tx_src = cfg[`VCCR_LOOP_BIT] ? loop_byte_q : i_enc_byte; // RQ24

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_sh_q   <= 8'h00;
            tx_left_q <= 4'h0;
            o_dx      <= 1'b0;
            o_dx_oe   <= 1'b0;
        end else if (i_tx_slot_start) begin
            tx_sh_q   <= {tx_src[6:0], 1'b0};
            tx_left_q <= 4'h7;
            o_dx      <= tx_src[7]; // RQ20
            o_dx_oe   <= 1'b1;
        end else if (i_tx_bit_en) begin
            if (tx_left_q == 4'h0) begin
                o_dx_oe <= 1'b0;
            end else begin
                o_dx      <= tx_sh_q[7];
                tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                tx_left_q <= tx_left_q - 4'h1;
                o_dx_oe   <= !(cfg[`VCCR_SEVEN_BIT] && tx_left_q == 4'h1); // RQ23
            end
        end
    end
endmodule

// ===== tb/tb_vccr_regs.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_vccr_regs;
    import vccr_pkg::*;
    logic       i_clk, i_rst_b, i_cs_b, i_sclk, i_sdi, o_sdo, o_sdo_oe, i_gci_mode;
    logic       i_dr, i_rx_bit_en, i_rx_slot_start, i_tx_bit_en, i_tx_slot_start;
    logic       o_dx, o_dx_oe, o_dec_valid, o_first_tone_enable, o_second_tone_enable;
    logic       o_waveform_select, o_tone_to_transmit, o_speaker_boost, o_anticlip_enable;
    logic       o_alaw, o_mu_d3d4, o_even_bit_invert, o_non_delayed, o_format_separated;
    logic       o_seven_bit_mode, o_codec_bypass, o_amp_mute;
    logic [3:0] o_ear_atten, o_spk_atten, o_tone_level;
    logic [1:0] o_threshold_sel, o_recovery_sel, o_clock_divider_sel;
    logic [10:0] o_first_tone_step, o_second_tone_step;
    vccr_byte_t i_enc_byte, o_dec_byte, dec_seen, q;
    int         n_mismatch, check_count, n_dec;
    int         mul [3] = '{4, 2, 8};
    logic [3:0] adr [6] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'h3};
    wire [5:0]  acl_w = {o_speaker_boost, o_anticlip_enable, o_threshold_sel, o_recovery_sel};
    wire [6:0]  cfg_w = {o_clock_divider_sel, o_alaw, o_mu_d3d4, o_even_bit_invert,
                         o_non_delayed, o_format_separated};

    vccr_regs dut (.i_clk, .i_rst_b, .i_cs_b, .i_sclk, .i_sdi, .o_sdo, .o_sdo_oe, .i_gci_mode,
        .i_dr, .i_rx_bit_en, .i_rx_slot_start, .i_enc_byte, .i_tx_bit_en, .i_tx_slot_start,
        .o_dx, .o_dx_oe, .o_dec_byte, .o_dec_valid, .o_ear_atten, .o_spk_atten, .o_tone_level,
        .o_first_tone_enable, .o_second_tone_enable, .o_waveform_select, .o_tone_to_transmit,
        .o_first_tone_step, .o_second_tone_step, .o_speaker_boost, .o_anticlip_enable,
        .o_threshold_sel, .o_recovery_sel, .o_clock_divider_sel, .o_alaw, .o_mu_d3d4,
        .o_even_bit_invert, .o_non_delayed, .o_format_separated, .o_seven_bit_mode,
        .o_codec_bypass, .o_amp_mute);
    vccr_host_model host (.i_clk(i_clk), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe),
        .o_cs_b(i_cs_b), .o_sclk(i_sclk), .o_sdi(i_sdi));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    always @(posedge i_clk) if (o_dec_valid === 1'b1) begin
        dec_seen <= o_dec_byte;
        n_dec++;
    end

    task automatic test_done();
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input vccr_byte_t d);
        vccr_byte_t r;
        host.xfer({4'h0, a}, d, 16, r);
    endtask

    task automatic rd(input logic [3:0] a, input vccr_byte_t e);
        vccr_byte_t r;
        host.xfer({4'h8, a}, 8'h00, 16, r);
        `CHK(r, e)
    endtask

    task automatic rx(input vccr_byte_t b);
        @(negedge i_clk) i_rx_slot_start = 1'b1;
        @(negedge i_clk) i_rx_slot_start = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            i_dr = b[i];
            i_rx_bit_en = 1'b1;
            @(negedge i_clk) i_rx_bit_en = 1'b0;
            i_dr = ~b[i];
            @(negedge i_clk);
        end
        repeat (2) @(negedge i_clk);
    endtask

    task automatic tx(input vccr_byte_t e, input vccr_byte_t x, input logic s);
        i_enc_byte = e;
        i_tx_slot_start = 1'b1;
        @(negedge i_clk) i_tx_slot_start = 1'b0;
        @(negedge i_clk);
        for (int i = 7; i >= 0; i--) begin
            `CHK(o_dx_oe, !(s && i == 0))
            if (o_dx_oe === 1'b1) `CHK(o_dx, x[i])
            i_tx_bit_en = 1'b1;
            @(negedge i_clk) i_tx_bit_en = 1'b0;
            @(negedge i_clk);
        end
        `CHK(o_dx_oe, 1'b0)
    endtask

    initial begin
        {i_gci_mode, i_dr, i_rx_bit_en, i_rx_slot_start, i_tx_bit_en, i_tx_slot_start} = '0;
        i_enc_byte = 8'h00;
        i_rst_b = 1'b0;
        repeat (10) @(negedge i_clk);
        i_rst_b = 1'b1;
        `CHK({o_clock_divider_sel, o_mu_d3d4, o_waveform_select}, 4'b0110)
        wr(4'h3, 8'h77);
        rd(4'h0, 8'h40);
        foreach (adr[k]) rd(adr[k], 8'h00);
        wr(4'h6, 8'hf3);
        `CHK({o_ear_atten, o_spk_atten}, 8'hf3)
        host.half = 5;
        wr(4'h6, 8'h0f);
        `CHK({o_ear_atten, o_spk_atten}, 8'h0f)
        host.half = 2;
        host.xfer(8'h06, 8'h55, 12, q);
        rd(4'h6, 8'h0f);
        for (int s = 0; s < 4; s++) begin
            wr(4'h7, {4'h9, s[1:0], 1'b1, s[0]});
            `CHK({o_tone_level, o_first_tone_enable, o_second_tone_enable, o_waveform_select,
                  o_tone_to_transmit}, {4'h9, s[1:0], 1'b1, s[0]})
        end
        wr(4'h8, 8'hff);
        wr(4'h9, 8'h01);
        rd(4'h8, 8'hff);
        for (int m = 0; m < 3; m++) begin
            wr(4'ha, {6'h00, m[1:0]});
            `CHK({o_first_tone_step, o_second_tone_step}, {11'(255 * mul[m]), 11'(mul[m])})
        end
        for (int c = 0; c < 16; c += 5) begin
            wr(4'ha, {2'b11, c[3:0], 2'b00});
            `CHK(acl_w, {2'b11, c[3:0]})
        end
        for (int l = 0; l < 4; l++) begin
            wr(4'h0, {2'b10, l[1:0], 4'b1100});
            `CHK(cfg_w, {2'b10, l[1], l == 0, l == 2, 2'b11})
        end
        i_gci_mode = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK({o_non_delayed, o_format_separated}, 2'b00)
        i_gci_mode = 1'b0;
        rd(4'h0, 8'hbc);
        wr(4'h0, 8'h40);
        rx(8'ha6);
        `CHK(dec_seen, 8'ha6)
        tx(8'h3c, 8'h3c, 1'b0);
        wr(4'h0, 8'h42);
        rx(8'h5b);
        `CHK({dec_seen, o_seven_bit_mode}, {8'h5a, 1'b1})
        tx(8'h3d, 8'h3d, 1'b1);
        wr(4'h0, 8'h41);
        rx(8'h5c);
        `CHK({n_dec[3:0], o_amp_mute, o_codec_bypass}, {4'd2, 2'b11})
        tx(8'h00, 8'h5c, 1'b0);
        test_done();
    end

    initial begin
        #2ms;
        n_mismatch++;
        test_done();
    end
endmodule

// ===== tb/vccr_host_model.sv
`timescale 1ns/10ps
module vccr_host_model (
    // Clock
    input  wire logic i_clk,
    // Read data from the device
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    // Control channel drive
    output logic      o_cs_b,
    output logic      o_sclk,
    output logic      o_sdi
);
    // Half period of the serial clock in system cycles; raise it for a slow host
    int half = 2;

    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Address byte then data byte, msb first; fewer than 16 bits aborts the pair
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int nbits,
                        output logic [7:0] q);
        logic [15:0] sh;
        sh = {a, d};
        q = 8'h00;
        wt(1);
        o_cs_b = 1'b0;
        wt(1);
        for (int i = 0; i < nbits; i++) begin
            o_sclk = 1'b0;
            o_sdi  = sh[15-i];
            wt(half);
            o_sclk = 1'b1;
            wt(half);
            // Read bits are taken just before each fall from the last address bit to the seventh data bit
            if (i >= 7 && i <= 14) q[14-i] = i_sdo_oe ? i_sdo : 1'bx;
        end
        o_sclk = 1'b0;
        wt(half);
        o_cs_b = 1'b1;
        o_sdi  = ~o_sdi;
    endtask
endmodule

// ===== tb/vccr_regs_checker.sv
`timescale 1ns/10ps
module vccr_regs_checker (
    // Clock, reset, chip select, strap
    input wire logic                 i_clk,
    input wire logic                 i_rst_b,
    input wire logic                 i_cs_b,
    input wire logic                 i_gci_mode,
    // PCM and read data enable
    input wire logic                 i_tx_slot_start,
    input wire vccr_pkg::vccr_byte_t i_enc_byte,
    input wire logic                 o_sdo_oe,
    input wire logic                 o_dx,
    input wire logic                 o_dx_oe,
    input wire vccr_pkg::vccr_byte_t o_dec_byte,
    input wire logic                 o_dec_valid,
    // Controls
    input wire logic [3:0]           o_tone_level,
    input wire logic [1:0]           o_clock_divider_sel,
    input wire logic                 o_alaw,
    input wire logic                 o_mu_d3d4,
    input wire logic                 o_even_bit_invert,
    input wire logic                 o_non_delayed,
    input wire logic                 o_format_separated,
    input wire logic                 o_seven_bit_mode,
    input wire logic                 o_codec_bypass,
    input wire logic                 o_amp_mute
);
    import vccr_pkg::*;
    vccr_byte_t enc_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) enc_q <= 8'h00;
        else if (i_tx_slot_start) enc_q <= i_enc_byte;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    reset_defaults_a: assert property ($rose(i_rst_b) |-> o_clock_divider_sel == 2'b01
        && o_mu_d3d4 && !o_alaw && !o_codec_bypass) else $error("reset values wrong");
    tone_level_cap_a: assert property (o_tone_level <= 4'h9)
        else $error("tone level above nine");
    law_mu_a: assert property (o_mu_d3d4 |-> !o_alaw && !o_even_bit_invert)
        else $error("mu code decoded wrong");
    law_invert_a: assert property (o_even_bit_invert |-> o_alaw)
        else $error("inversion without a-law");
    gci_ignore_a: assert property (i_gci_mode && $past(i_gci_mode)
        |-> !o_non_delayed && !o_format_separated) else $error("timing bits live in gci");
    loop_mute_a: assert property (o_codec_bypass == o_amp_mute)
        else $error("loopback without mute");
    loop_no_dec_a: assert property (o_codec_bypass && $past(o_codec_bypass, 2)
        |-> !o_dec_valid) else $error("decoder fed in loopback");
    seven_lsb_a: assert property (o_dec_valid && o_seven_bit_mode
        |-> o_dec_byte[0] == 1'b0) else $error("lsb kept in seven bit mode");
    tx_msb_first_a: assert property (i_tx_slot_start && !o_codec_bypass
        |-> ##2 o_dx_oe && o_dx == enc_q[7]) else $error("transmit msb wrong");
    sdo_quiet_a: assert property (i_cs_b && $past(i_cs_b) |-> !o_sdo_oe)
        else $error("read data driven outside frame");

    cover property (o_sdo_oe);
    cover property (o_codec_bypass && o_dx_oe);
    cover property (o_dec_valid && o_seven_bit_mode);
    cover property (o_even_bit_invert);
endmodule

bind vccr_regs vccr_regs_checker u_chk (.i_clk, .i_rst_b, .i_cs_b, .i_gci_mode,
    .i_tx_slot_start, .i_enc_byte, .o_sdo_oe, .o_dx, .o_dx_oe, .o_dec_byte,
    .o_dec_valid, .o_tone_level, .o_clock_divider_sel, .o_alaw, .o_mu_d3d4,
    .o_even_bit_invert, .o_non_delayed, .o_format_separated, .o_seven_bit_mode,
    .o_codec_bypass, .o_amp_mute);
